// ===== src/gdi_core.sv
// Purpose: dual-channel gate drive control with interlock, lockout and status pins
// Assumes: all pins synchronous to clk; Avalon-MM slave with byte addresses
// Notes: gate switch pairs and status enables come from flip-flops
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module gdi_core #(
   parameter int CYC_PER_MS = gdi_pkg::CYC_PER_MS_DEF
) (
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // Host logic inputs and straps
   input wire logic pwmInputA,
   input wire logic enableInputB,
   input wire logic modeStrapShort,
   input wire logic blockingTimeStrapShort,
   // Supply monitors
   input wire logic primaryUv,
   input wire gdi_pkg::gdi_uv_t uvCh1,
   input wire gdi_pkg::gdi_uv_t uvCh2,
   // Gate drive switches
   output gdi_pkg::gdi_gate_t gateCh1,
   output gdi_pkg::gdi_gate_t gateCh2,
   // Open-drain status pins, enable low while pulling down
   input wire logic faultStatusCh1In,
   output logic faultStatusCh1Out,
   output logic faultStatusCh1Oe_n,
   input wire logic faultStatusCh2In,
   output logic faultStatusCh2Out,
   output logic faultStatusCh2Oe_n
);
   import gdi_pkg::*;

   // Clamp a dead interval setting into its legal range
   function automatic logic [7:0] clampDead(input logic [7:0] v);
      if (v < DEAD_MIN_CYC) begin
         return DEAD_MIN_CYC;
      end else if (v > DEAD_MAX_CYC) begin
         return DEAD_MAX_CYC;
      end
      return v;
   endfunction

   // Clamp a blocking setting into its legal range
   function automatic logic [7:0] clampBlock(input logic [7:0] v);
      if (v < BLOCK_MIN_MS) begin
         return BLOCK_MIN_MS;
      end else if (v > BLOCK_MAX_MS) begin
         return BLOCK_MAX_MS;
      end
      return v;
   endfunction

   // ---------------- Register bus ----------------
   logic ack_ff;
   logic [31:0] readData_ff;
   logic [7:0] deadCfg_ff;
   logic [7:0] blockCfg_ff;
   logic [31:0] nxt_readData;
   logic request;
   logic writeDone;
   logic selDead;
   logic selBlock;
   logic selStatus;
   logic [7:0] statusBits;

   // Address decode and handshake
   assign request = avsRead | avsWrite;
   assign avsWaitRequest = request & ~ack_ff;
   assign writeDone = avsWrite & ack_ff & avsByteEnable[0];
   assign selDead = (avsAddress == REG_DEAD_CFG);
   assign selBlock = (avsAddress == REG_BLOCK_CFG);
   assign selStatus = (avsAddress == REG_STATUS);
   assign avsReadData = readData_ff;

   // Read data mux; unmapped offsets read zero
   assign nxt_readData = selDead ? {24'h000000, deadCfg_ff} :
                         selBlock ? {24'h000000, blockCfg_ff} :
                         selStatus ? {24'h000000, statusBits} : 32'h00000000;

   // Bus answer one cycle after the request appears
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_ff <= 1'b0;
         readData_ff <= 32'h00000000;
      end else begin
         ack_ff <= request & ~ack_ff;
         if (avsRead & ~ack_ff) begin
            readData_ff <= nxt_readData;
         end
      end
   end

   // Configuration registers, written at the completing edge
   always_ff @(posedge clk) begin
      if (reset) begin
         deadCfg_ff <= DEAD_NOM_CYC;
         blockCfg_ff <= BLOCK_NOM_MS;
      end else if (writeDone) begin
         if (selDead) begin
            deadCfg_ff <= clampDead(avsWriteData[7:0]);
         end
         if (selBlock) begin
            blockCfg_ff <= clampBlock(avsWriteData[7:0]);
         end
      end
   end

   // ---------------- Blocking period ----------------
   logic [31:0] blockCyc;
   logic [31:0] cycPerMs;

   // Shorted strap overrides the programmed period
   assign cycPerMs = 32'(CYC_PER_MS);
   assign blockCyc = blockingTimeStrapShort ? BLOCK_SHORT_CYC :
                     32'({24'h000000, blockCfg_ff} * cycPerMs);

   // ---------------- Lockouts ----------------
   logic primLocked;
   logic ch1Locked;
   logic ch2Locked;
   logic ch1Fault;
   logic ch2Fault;

   // Either secondary rail falling short faults its own channel
   assign ch1Fault = uvCh1.posUv | uvCh1.negUv;
   assign ch2Fault = uvCh2.posUv | uvCh2.negUv;

   // Primary lockout counts from the clear
   gdi_lockout uPrim (
      .clk(clk),
      .reset(reset),
      .fault(primaryUv),
      .startAtDetect(1'b0),
      .targetCyc(blockCyc),
      .locked(primLocked)
   );

   // Channel lockouts count from detection, one timer each
   gdi_lockout uCh1 (
      .clk(clk),
      .reset(reset),
      .fault(ch1Fault),
      .startAtDetect(1'b1),
      .targetCyc(blockCyc),
      .locked(ch1Locked)
   );

   gdi_lockout uCh2 (
      .clk(clk),
      .reset(reset),
      .fault(ch2Fault),
      .startAtDetect(1'b1),
      .targetCyc(blockCyc),
      .locked(ch2Locked)
   );

   // ---------------- Transmission logic ----------------
   logic halfBridge;
   logic hb1Req;
   logic hb2Req;
   logic ch1Req;
   logic ch2Req;

   // Resistor on the mode strap selects half-bridge
   assign halfBridge = ~modeStrapShort;

   gdi_dead uDead (
      .clk(clk),
      .reset(reset),
      .pwm(pwmInputA),
      .enable(enableInputB & halfBridge),
      .deadCyc(deadCfg_ff),
      .ch1Req(hb1Req),
      .ch2Req(hb2Req)
   );

   // Mode picks direct inputs or sequencer
   assign ch1Req = halfBridge ? hb1Req : pwmInputA;
   assign ch2Req = halfBridge ? hb2Req : enableInputB;

   // ---------------- Gate drive and status ----------------
   logic [1:0] wantOn;
   logic [1:0] chanLocked;
   logic [1:0] on_ff;
   logic [1:0] pull_ff;

   assign wantOn = {ch2Req, ch1Req};
   assign chanLocked = {ch2Locked, ch1Locked};

   // Each channel: gate and status from its lockout and the primary lockout
   for (genvar i = 0; i < 2; i++) begin : gChan
      always_ff @(posedge clk) begin
         if (reset) begin
            on_ff[i] <= 1'b0;
            pull_ff[i] <= 1'b1;
         end else begin
            on_ff[i] <= wantOn[i] & ~chanLocked[i] & ~primLocked;
            pull_ff[i] <= chanLocked[i] | primLocked;
         end
      end
   end

   // Complementary switch pair, never both closed
   assign gateCh1.turnOnSwitch = on_ff[0];
   assign gateCh1.turnOffSwitch = ~on_ff[0];
   assign gateCh2.turnOnSwitch = on_ff[1];
   assign gateCh2.turnOffSwitch = ~on_ff[1];

   // Open-drain: drive low only in fault, float otherwise
   assign faultStatusCh1Out = 1'b0;
   assign faultStatusCh2Out = 1'b0;
   assign faultStatusCh1Oe_n = ~pull_ff[0];
   assign faultStatusCh2Oe_n = ~pull_ff[1];

   // Status word visible to software
   assign statusBits[ST_HALF_BRIDGE] = halfBridge;
   assign statusBits[ST_PRIM_LOCK] = primLocked;
   assign statusBits[ST_CH1_LOCK] = ch1Locked;
   assign statusBits[ST_CH2_LOCK] = ch2Locked;
   assign statusBits[ST_CH1_ON] = on_ff[0];
   assign statusBits[ST_CH2_ON] = on_ff[1];
   assign statusBits[ST_PIN1] = faultStatusCh1In;
   assign statusBits[ST_PIN2] = faultStatusCh2In;
endmodule
`default_nettype wire

// ===== src/gdi_pkg.sv
// Purpose: constants and types for the dual gate drive interlock and lockout block
// Assumes: clk at 20 MHz, synchronous active-high reset
// Notes: Behaviour list below
//
// Behaviour
// - Primary undervoltage forces both gates off and pulls both status pins low.
// - After primary undervoltage clears, stay locked one blocking period, then release.
// - Channel positive-supply undervoltage turns that gate off and pulls its status low.
// - Channel blocking timer starts at detection; a new fault restarts it.
// - Channel status released only after supply recovered and blocking period elapsed.
// - Channel negative-supply undervoltage locks out exactly like positive-supply undervoltage.
// - Mode strap shorted gives direct mode, resistor gives half-bridge mode.
// - Direct mode: input A drives channel one, input B channel two, high on.
// - Half-bridge: enable low holds both off; high lets PWM govern both.
// - Half-bridge PWM rise: channel two off now, channel one on after dead interval.
// - Half-bridge PWM fall: channel one off now, channel two on after dead interval.
// - Dead interval configurable 0.613 to 4.28 us, nominal 3.2 us.
// - Each status pin is open-drain: floats when healthy, pulled low in fault.
// - Status returns only after blocking period, configurable 20 to 130 ms.
// - Blocking strap shorted fixes the blocking period at 10 us.
// - On closes turn-on switch and opens turn-off switch; never both closed.
package gdi_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // Dead interval, nanoseconds as specified, cycle counts derived
   localparam int DEAD_NOM_NS = 3200;
   localparam int DEAD_MIN_NS = 613;
   localparam int DEAD_MAX_NS = 4280;
   localparam logic [7:0] DEAD_NOM_CYC = 8'((DEAD_NOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DEAD_MIN_CYC = 8'((DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] DEAD_MAX_CYC = 8'(DEAD_MAX_NS / CLK_PERIOD_NS);
   // Blocking period, milliseconds as specified, strap value in nanoseconds
   localparam logic [7:0] BLOCK_NOM_MS = 8'd95;
   localparam logic [7:0] BLOCK_MIN_MS = 8'd20;
   localparam logic [7:0] BLOCK_MAX_MS = 8'd130;
   localparam int BLOCK_SHORT_NS = 10000;
   localparam logic [31:0] BLOCK_SHORT_CYC = 32'(BLOCK_SHORT_NS / CLK_PERIOD_NS);
   localparam int CYC_PER_MS_DEF = 1000000 / CLK_PERIOD_NS;
   // Register byte offsets
   localparam logic [3:0] REG_DEAD_CFG = 4'h0;
   localparam logic [3:0] REG_BLOCK_CFG = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   // Status register bit positions
   localparam int ST_HALF_BRIDGE = 0;
   localparam int ST_PRIM_LOCK = 1;
   localparam int ST_CH1_LOCK = 2;
   localparam int ST_CH2_LOCK = 3;
   localparam int ST_CH1_ON = 4;
   localparam int ST_CH2_ON = 5;
   localparam int ST_PIN1 = 6;
   localparam int ST_PIN2 = 7;

   // Gate drive switch pair of one channel
   typedef struct packed {
      logic turnOnSwitch;
      logic turnOffSwitch;
   } gdi_gate_t;

   // Secondary supply monitor indications of one channel
   typedef struct packed {
      logic posUv;
      logic negUv;
   } gdi_uv_t;

   // Half-bridge sequencer states
   typedef enum logic [4:0] {
      HB_OFF = 5'b00001,
      HB_WAIT1 = 5'b00010,
      HB_ON1 = 5'b00100,
      HB_WAIT2 = 5'b01000,
      HB_ON2 = 5'b10000
   } gdi_hb_state_t;
endpackage

// ===== src/gdi_lockout.sv
// Purpose: one undervoltage lockout with its blocking period timer
// Assumes: target count stable while counting; fault level synchronous to clk
// Notes: startAtDetect selects secondary-side timing, else primary-side timing
`timescale 1ns/1ns
`default_nettype none
module gdi_lockout (
   input wire logic clk,
   input wire logic reset,
   input wire logic fault,
   input wire logic startAtDetect,
   input wire logic [31:0] targetCyc,
   output logic locked
);
   import gdi_pkg::*;

   logic busy_ff;
   logic faultPrev_ff;
   logic [31:0] cnt_ff;
   logic nxt_busy;
   logic [31:0] nxt_cnt;
   logic restart;
   logic expired;

   // Detection restarts on a new fault; primary timing holds at zero while fault stands
   assign restart = startAtDetect ? (fault & ~faultPrev_ff) : fault;
   assign expired = busy_ff & (cnt_ff >= targetCyc - 32'd1);
   assign nxt_busy = restart | (busy_ff & ~expired);
   assign nxt_cnt = (restart | ~busy_ff) ? 32'd0 : cnt_ff + 32'd1;
   assign locked = fault | busy_ff;

   // Timer state; reset enters lockout
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_ff <= 1'b1;
         faultPrev_ff <= 1'b0;
         cnt_ff <= 32'd0;
      end else begin
         busy_ff <= nxt_busy;
         faultPrev_ff <= fault;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

// ===== src/gdi_dead.sv
// Purpose: half-bridge sequencer with dead interval between channels
// Assumes: deadCyc at least one
// Notes: opposite channel drops the cycle after the PWM edge is seen
`timescale 1ns/1ns
`default_nettype none
module gdi_dead (
   input wire logic clk,
   input wire logic reset,
   input wire logic pwm,
   input wire logic enable,
   input wire logic [7:0] deadCyc,
   output logic ch1Req,
   output logic ch2Req
);
   import gdi_pkg::*;

   gdi_hb_state_t state_ff;
   gdi_hb_state_t nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic done;

   assign done = cnt_ff >= deadCyc - 8'd1;

   // Next state: PWM level picks the side, dead wait precedes every turn-on
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 8'd1;
      if (!enable) begin
         nxt_state = HB_OFF;
         nxt_cnt = 8'd0;
      end else begin
         unique case (state_ff)
            HB_OFF: begin
               nxt_state = pwm ? HB_WAIT1 : HB_WAIT2;
               nxt_cnt = 8'd0;
            end
            HB_WAIT1: begin
               if (!pwm) begin
                  nxt_state = HB_WAIT2;
                  nxt_cnt = 8'd0;
               end else if (done) begin
                  nxt_state = HB_ON1;
               end
            end
            HB_ON1: begin
               if (!pwm) begin
                  nxt_state = HB_WAIT2;
               end
               nxt_cnt = 8'd0;
            end
            HB_WAIT2: begin
               if (pwm) begin
                  nxt_state = HB_WAIT1;
                  nxt_cnt = 8'd0;
               end else if (done) begin
                  nxt_state = HB_ON2;
               end
            end
            HB_ON2: begin
               if (pwm) begin
                  nxt_state = HB_WAIT1;
               end
               nxt_cnt = 8'd0;
            end
            default: begin
               nxt_state = HB_OFF;
               nxt_cnt = 8'd0;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= HB_OFF;
         cnt_ff <= 8'd0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   assign ch1Req = (state_ff == HB_ON1);
   assign ch2Req = (state_ff == HB_ON2);
endmodule
`default_nettype wire

// ===== test/gdi_core_sva.sv
// Purpose: assertion checker on the gdi_core ports
// Assumes: synchronous active-high reset, one clock
// Notes: bound into gdi_core below the module
`timescale 1ns/1ns
`default_nettype none
module gdi_core_sva #(
   parameter int CYC_PER_MS = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic pwmInputA,
   input wire logic enableInputB,
   input wire logic modeStrapShort,
   input wire logic primaryUv,
   input wire gdi_pkg::gdi_uv_t uvCh1,
   input wire gdi_pkg::gdi_gate_t gateCh1,
   input wire gdi_pkg::gdi_gate_t gateCh2,
   input wire logic faultStatusCh1Oe_n,
   input wire logic faultStatusCh2Oe_n
);
   import gdi_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // Gate pairs, lockout, direct mode and half-bridge sequencing
   property p_pairs; (gateCh1 == 2'h1 || gateCh1 == 2'h2) && (gateCh2 == 2'h1 || gateCh2 == 2'h2);
   endproperty
   a_pairs: assert property (p_pairs) else $error("gate switch pair not complementary");
   property p_primOff; primaryUv[*3] |-> !gateCh1.turnOnSwitch && !gateCh2.turnOnSwitch
      && !faultStatusCh1Oe_n && !faultStatusCh2Oe_n;
   endproperty
   a_primOff: assert property (p_primOff) else $error("primary undervoltage not locked");
   property p_primHold; $fell(primaryUv) |-> (!faultStatusCh1Oe_n && !faultStatusCh2Oe_n)[*8];
   endproperty
   a_primHold: assert property (p_primHold) else $error("status released at clear");
   property p_ch1Uv; uvCh1.posUv[*3] |-> !gateCh1.turnOnSwitch && !faultStatusCh1Oe_n;
   endproperty
   a_ch1Uv: assert property (p_ch1Uv) else $error("channel fault not locked");
   property p_ch1Neg; uvCh1.negUv[*3] |-> !gateCh1.turnOnSwitch && !faultStatusCh1Oe_n;
   endproperty
   a_ch1Neg: assert property (p_ch1Neg) else $error("negative rail fault not locked");
   property p_direct; modeStrapShort && $past(modeStrapShort) && $past(modeStrapShort, 2)
      && faultStatusCh1Oe_n |-> gateCh1.turnOnSwitch == $past(pwmInputA);
   endproperty
   a_direct: assert property (p_direct) else $error("direct gate not following input");
   property p_enOff; (!modeStrapShort && !enableInputB)[*3] |-> gateCh1 == 2'h1 && gateCh2 == 2'h1;
   endproperty
   a_enOff: assert property (p_enOff) else $error("gate on while disabled");
   property p_riseOff; $rose(pwmInputA) && !modeStrapShort && !$past(modeStrapShort)
      |-> ##2 !gateCh2.turnOnSwitch;
   endproperty
   a_riseOff: assert property (p_riseOff) else $error("channel two late off");
   property p_deadGap; $rose(pwmInputA) && !modeStrapShort |-> ##3 (!gateCh1.turnOnSwitch)[*8];
   endproperty
   a_deadGap: assert property (p_deadGap) else $error("channel one on before dead");
   property p_fallOff; $fell(pwmInputA) && !modeStrapShort && !$past(modeStrapShort)
      |-> ##2 !gateCh1.turnOnSwitch;
   endproperty
   a_fallOff: assert property (p_fallOff) else $error("channel one late off");
   // Main scenarios reached
   c_hbOn: cover property (!modeStrapShort && $rose(gateCh1.turnOnSwitch));
   c_release: cover property ($rose(faultStatusCh1Oe_n));
   c_primClear: cover property ($fell(primaryUv));
endmodule
bind gdi_core gdi_core_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (.clk(clk), .reset(reset),
   .pwmInputA(pwmInputA), .enableInputB(enableInputB), .modeStrapShort(modeStrapShort),
   .primaryUv(primaryUv), .uvCh1(uvCh1), .gateCh1(gateCh1), .gateCh2(gateCh2),
   .faultStatusCh1Oe_n(faultStatusCh1Oe_n), .faultStatusCh2Oe_n(faultStatusCh2Oe_n));
`default_nettype wire

// ===== test/gdi_host_model.sv
// Purpose: host controller model with status pull-ups
// Assumes: commands from the bench, one clock
// Notes: keeps one input low before raising the other in direct mode
`timescale 1ns/1ns
`default_nettype none
module gdi_host_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic reqA,
   input wire logic reqB,
   input wire logic directMode,
   input wire logic s1Out,
   input wire logic s1Oe_n,
   input wire logic s2Out,
   input wire logic s2Oe_n,
   output logic pwmA,
   output logic enB,
   output logic pin1,
   output logic pin2,
   output logic pinsJoined
);
   // Pull-up resistors set the level while nobody sinks the pin
   assign pin1 = s1Oe_n ? 1'h1 : s1Out;
   assign pin2 = s2Oe_n ? 1'h1 : s2Out;
   assign pinsJoined = pin1 & pin2;
   // Input drive with host-side dead gap in direct mode
   always_ff @(posedge clk) begin
      if (reset) begin
         pwmA <= 1'h0;
         enB <= 1'h0;
      end
      else begin
         pwmA <= reqA && !(directMode && enB);
         enB <= reqB && !(directMode && (pwmA || reqA));
      end
   end
endmodule
`default_nettype wire

// ===== test/gdi_core_tb_top.sv
// Purpose: self-checking bench for gdi_core
// Assumes: 20 MHz clock, CYC_PER_MS shortened to 10
// Notes: one task per scenario, bus through Avalon-MM tasks
`timescale 1ns/1ns
`default_nettype none
module gdi_core_tb_top;
   import gdi_pkg::*;
   localparam int CPM = 10;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [3:0] avsAddress = 4'h0;
   logic avsRead = 1'h0;
   logic avsWrite = 1'h0;
   logic [31:0] avsWriteData = 32'h0;
   logic [3:0] avsByteEnable = 4'hF;
   logic [31:0] avsReadData, rd;
   logic avsWaitRequest, reqA = 1'h0, reqB = 1'h0, modeShort = 1'h1, blockShort = 1'h1;
   logic primaryUv = 1'h0;
   gdi_uv_t uvCh1 = 2'h0;
   gdi_uv_t uvCh2 = 2'h0;
   gdi_gate_t gateCh1, gateCh2;
   logic pwmA, enB, pin1, pin2, pinsJoined, s1Out, s1Oe_n, s2Out, s2Oe_n;
   int badCount = 0;
   int compares = 0;
   int cyc = 0;
   int t0;
   gdi_core #(.CYC_PER_MS(CPM)) dut (.clk(clk), .reset(reset), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .pwmInputA(pwmA), .enableInputB(enB), .modeStrapShort(modeShort),
      .blockingTimeStrapShort(blockShort), .primaryUv(primaryUv), .uvCh1(uvCh1), .uvCh2(uvCh2),
      .gateCh1(gateCh1), .gateCh2(gateCh2), .faultStatusCh1In(pin1), .faultStatusCh1Out(s1Out),
      .faultStatusCh1Oe_n(s1Oe_n), .faultStatusCh2In(pin2), .faultStatusCh2Out(s2Out),
      .faultStatusCh2Oe_n(s2Oe_n));
   gdi_host_model host (.clk(clk), .reset(reset), .reqA(reqA), .reqB(reqB),
      .directMode(modeShort), .s1Out(s1Out), .s1Oe_n(s1Oe_n), .s2Out(s2Out), .s2Oe_n(s2Oe_n),
      .pwmA(pwmA), .enB(enB), .pin1(pin1), .pin2(pin2), .pinsJoined(pinsJoined));
   // Clock and cycle count
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // Comparisons and reporting
   task automatic miss(input string msg);
      badCount++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic checkBit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) miss(msg);
   endtask
   task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) miss(msg);
   endtask
   task automatic checkSpan(input int got, input int lo, input int hi, input string msg);
      compares++;
      if (got < lo || got > hi) miss(msg);
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic busDo(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= adr;
      avsWriteData <= wd;
      avsWrite <= wr;
      avsRead <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitRequest !== 1'h0);
      rd = avsReadData;
      avsWrite <= 1'h0;
      avsRead <= 1'h0;
      checkSpan(n, 2, 2, "bus answer");
   endtask
   function automatic logic probe(input int sel);
      case (sel)
         0: return pin1;
         2: return gateCh1.turnOnSwitch;
         default: return gateCh2.turnOnSwitch;
      endcase
   endfunction
   // Wait for a level and judge the elapsed cycles
   task automatic waitFor(input int sel, input logic v, input int lo, input int hi, input string m);
      while (probe(sel) !== v && cyc - t0 <= hi) @(posedge clk);
      checkSpan(cyc - t0, lo, hi, m);
   endtask
   task automatic testReset();
      t0 = cyc;
      checkBit(gateCh1.turnOffSwitch, 1'h1, "ch1 off at start");
      checkBit(pin1, 1'h0, "pin1 low at start");
      busDo(1'h0, REG_DEAD_CFG, 32'h0);
      checkWord(rd, 32'h40, "dead default");
      busDo(1'h0, REG_BLOCK_CFG, 32'h0);
      checkWord(rd, 32'h5F, "blocking default");
      busDo(1'h0, 4'hC, 32'h0);
      checkWord(rd, 32'h0, "unmapped read");
      waitFor(0, 1'h1, 198, 206, "short strap lockout");
      checkBit(pin2, 1'h1, "pin2 released");
   endtask
   task automatic testDirect();
      reqA <= 1'h1;
      t0 = cyc;
      waitFor(2, 1'h1, 2, 4, "ch1 follows input");
      checkBit(gateCh1.turnOffSwitch, 1'h0, "ch1 off switch open");
      checkBit(gateCh2.turnOnSwitch, 1'h0, "ch2 stays off");
      reqA <= 1'h0;
      reqB <= 1'h1;
      t0 = cyc;
      waitFor(3, 1'h1, 3, 5, "ch2 follows input");
      checkBit(gateCh1.turnOnSwitch, 1'h0, "ch1 off again");
      checkBit(pinsJoined, 1'h1, "joined status high");
      busDo(1'h0, REG_STATUS, 32'h0);
      checkBit(rd[ST_HALF_BRIDGE], 1'h0, "direct mode flag");
   endtask
   task automatic testPrimary();
      busDo(1'h1, REG_BLOCK_CFG, 32'hC8);
      busDo(1'h0, REG_BLOCK_CFG, 32'h0);
      checkWord(rd, 32'h82, "blocking clamp");
      busDo(1'h1, REG_BLOCK_CFG, 32'h15);
      blockShort <= 1'h0;
      primaryUv <= 1'h1;
      repeat (5) @(posedge clk);
      checkBit(gateCh2.turnOnSwitch, 1'h0, "ch2 forced off");
      checkBit(pin1 | pin2, 1'h0, "both pins low");
      busDo(1'h0, REG_STATUS, 32'h0);
      checkBit(rd[ST_PRIM_LOCK], 1'h1, "primary lock flag");
      checkBit(rd[ST_PIN1], 1'h0, "pin1 sensed low");
      primaryUv <= 1'h0;
      t0 = cyc;
      waitFor(0, 1'h1, 21 * CPM - 1, 21 * CPM + 6, "primary hold");
      blockShort <= 1'h1;
   endtask
   task automatic testChannel();
      reqB <= 1'h0;
      reqA <= 1'h1;
      repeat (6) @(posedge clk);
      uvCh1 <= 2'h2;
      t0 = cyc;
      repeat (4) @(posedge clk);
      checkBit(gateCh1.turnOnSwitch, 1'h0, "ch1 off on fault");
      checkBit(pin1, 1'h0, "pin1 low on fault");
      checkBit(pin2, 1'h1, "pin2 unaffected");
      uvCh1 <= 2'h0;
      repeat (96) @(posedge clk);
      uvCh1 <= 2'h1;
      repeat (4) @(posedge clk);
      uvCh1 <= 2'h0;
      waitFor(0, 1'h1, 299, 306, "timer restart");
      repeat (3) @(posedge clk);
      checkBit(gateCh1.turnOnSwitch, 1'h1, "ch1 back on");
   endtask
   task automatic testHalf();
      reqA <= 1'h0;
      modeShort <= 1'h0;
      busDo(1'h1, REG_DEAD_CFG, 32'h5);
      busDo(1'h0, REG_STATUS, 32'h0);
      checkBit(rd[ST_HALF_BRIDGE], 1'h1, "half-bridge flag");
      busDo(1'h0, REG_DEAD_CFG, 32'h0);
      checkWord(rd, 32'h0D, "dead clamp");
      reqB <= 1'h1;
      t0 = cyc;
      waitFor(3, 1'h1, 1, 30, "ch2 enabled");
      reqA <= 1'h1;
      t0 = cyc;
      waitFor(3, 1'h0, 3, 5, "ch2 drops");
      waitFor(2, 1'h1, 17, 19, "ch1 after dead");
      reqA <= 1'h0;
      t0 = cyc;
      waitFor(2, 1'h0, 3, 5, "ch1 drops");
      waitFor(3, 1'h1, 17, 19, "ch2 after dead");
      reqB <= 1'h0;
      repeat (5) @(posedge clk);
      checkBit(gateCh2.turnOnSwitch, 1'h0, "disabled off");
      modeShort <= 1'h1;
   endtask
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("No errors found");
      end
      else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      testReset();
      $display("reset test done");
      testDirect();
      $display("direct test done");
      testPrimary();
      $display("primary test done");
      testChannel();
      $display("channel test done");
      testHalf();
      $display("half-bridge test done");
      completeRun();
   end
   // Watchdog against a hang
   initial begin
      repeat (4000) @(posedge clk);
      miss("watchdog expired");
      completeRun();
   end
endmodule
`default_nettype wire
